// [bench/tb.sv]
// Purpose : self-checking bench of the interrupt logic
// Assumes : default state width of 4
// Notes   : random events with fixed seed, clears rotated per group
`timescale 1ns/1ps
module tb;
   logic ref_clk = 1'b0, reset = 1'b1, bus_wr = 1'b0, bus_rd = 1'b0, auto_en = 1'b0;
   logic [7:0] bus_addr = 8'h00;
   logic [31:0] bus_wdata = 32'h0, v;
   logic [3:0] state_status_bits = 4'h0;
   logic power_on_flag = 1'b0, p_on_aux_flag = 1'b0, b, h_rd, h_wr;
   logic [4:0] tx_count = 5'h00, rx_count = 5'h00;
   tirq_pkg::tirq_src_t src = '0;
   tirq_pkg::tirq_clr_t tclr = '0, clr_w;
   tirq_pkg::tirq_ctrl_t ctrl_out;
   wire [31:0] bus_rdata;
   wire irq_out;
   int err_count = 0, n_compared = 0, i, k, s;
   int sc[4] = '{0, 6, 3, 4}, tc[5] = '{1, 2, 5, 3, 4}, rc[4] = '{2, 5, 3, 4};
   assign clr_w = tclr | {h_rd, h_wr, 2'h0};
   always #12.5 ref_clk = ~ref_clk;
   tirq_irq_logic tirq_irq_logic_inst (.ref_clk, .reset, .bus_addr, .bus_wdata, .bus_wr,
      .bus_rd, .bus_rdata, .state_status_bits, .power_on_flag, .p_on_aux_flag, .tx_count,
      .rx_count, .src, .clr(clr_w), .ctrl_out, .irq_out);
   tirq_host_model tirq_host_model_inst (.ref_clk, .reset, .auto_en, .irq_out,
      .rd_stb(h_rd), .wr_stb(h_wr));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [4:0] lvl(input logic [1:0] t);
      return (t == 2'h3) ? 5'h00 : ({3'h0, t} + 5'h01) << 2;
   endfunction : lvl
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic conclude;
      if (err_count == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : conclude
   // bus cycles: one strobe cycle each, read data taken one cycle later
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      bus_addr  <= a;
      bus_wdata <= d;
      bus_wr    <= 1'b1;
      @(posedge ref_clk);
      bus_wr <= 1'b0;
      #1;
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      @(posedge ref_clk);
      bus_addr <= a;
      bus_rd   <= 1'b1;
      @(posedge ref_clk);
      bus_rd <= 1'b0;
      #1 chk(bus_rdata, exp);
   endtask : rdc
   // one-cycle source and clear pulses, counts presented beside them
   task automatic ev(input logic [4:0] e, input logic [3:0] c, input logic [4:0] n);
      @(posedge ref_clk);
      src      <= e;
      tclr     <= c;
      tx_count <= n;
      rx_count <= n;
      @(posedge ref_clk);
      src  <= '0;
      tclr <= '0;
      #1;
   endtask : ev
   task automatic clr_by(input int c, input int g, input logic [31:0] cv);
      case (c)
         0, 1, 2, 3: ev(5'h00, 4'h8 >> c, 5'h00);
         4: wr(tirq_pkg::OFF_CLEAR, 32'h1 << g);
         5: wr(tirq_pkg::OFF_CTRL, cv);
         default: rdc(tirq_pkg::OFF_STATE, {26'h0, p_on_aux_flag, power_on_flag,
            state_status_bits});
      endcase
      chk(irq_out, 1'b0);
   endtask : clr_by
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'h476b));
      repeat (20) @(posedge ref_clk);
      reset <= 1'b0;
      rdc(tirq_pkg::OFF_CTRL, 0);
      rdc(tirq_pkg::OFF_ENABLE, 7);
      wr(tirq_pkg::OFF_STATUS, 7);
      rdc(tirq_pkg::OFF_STATUS, 0);
      rdc(8'h14, 0);
      // status events: state toggles, power flags both ways
      for (i = 0; i < 12; i++) begin
         v = $urandom;
         @(posedge ref_clk);
         case (i % 3)
            0: state_status_bits <= state_status_bits ^ (v[3:0] | 4'h1);
            1: power_on_flag <= !power_on_flag;
            default: p_on_aux_flag <= !p_on_aux_flag;
         endcase
         @(posedge ref_clk) #1;
         b = (i % 3 == 0) | (i % 3 == 1 & power_on_flag) | (i % 3 == 2 & p_on_aux_flag);
         chk(irq_out, b);
         if (b) clr_by(sc[i % 4], 0, 0);
      end
      // tx levels; t_mode set in the last four rounds; round 5 always hits so the host runs
      for (i = 0; i < 16; i++) begin
         v = $urandom | (i == 5);
         s = i % 4;
         b = i >= 12;
         wr(tirq_pkg::OFF_CTRL, {26'h0, tirq_pkg::OPM_TX, 1'b0, b, s[1:0]});
         chk(ctrl_out, {tirq_pkg::OPM_TX, 1'b0, b, s[1:0]});
         ev(5'h10, 4'h0, v[0] ? lvl(s[1:0]) : lvl(s[1:0]) ^ 5'h01);
         chk(irq_out, v[0] & !b);
         if (irq_out !== 1'b1) continue;
         ev(5'h00, 4'h8, 5'h00);
         chk(irq_out, 1'b1);
         if (i != 5) begin
            clr_by(tc[i % 5], 1, {26'h0, tirq_pkg::OPM_TX, 4'h0});
            continue;
         end
         @(posedge ref_clk) auto_en <= 1'b1;
         for (k = 0; k < 10 && irq_out !== 1'b0; k++) @(posedge ref_clk);
         chk(irq_out, 1'b0);
         if (irq_out !== 1'b0) conclude();
         auto_en <= 1'b0;
      end
      // rx levels and error, suppressed while the buffer is read
      for (i = 0; i < 16; i++) begin
         v = $urandom;
         s = i % 4;
         b = i >= 12;
         wr(tirq_pkg::OFF_CTRL, {26'h0, tirq_pkg::OPM_RX, 2'h0, s[1:0]});
         ev((s == 3 ? 5'h04 : 5'h08) | b, 4'h0, v[0] ? lvl(s[1:0]) : lvl(s[1:0]) ^ 5'h01);
         chk(irq_out, (s == 3 | v[0]) & !b);
         if (irq_out === 1'b1) clr_by(rc[i % 4], 2, {26'h0, tirq_pkg::OPM_RX, 4'h0});
      end
      // bit check with and without pattern mode
      for (i = 0; i < 2; i++) begin
         wr(tirq_pkg::OFF_CTRL, {26'h0, tirq_pkg::OPM_RX, i[0], 3'h0});
         ev(5'h02, 4'h0, 5'h00);
         chk(irq_out, !i[0]);
         clr_by(3, 2, 0);
      end
      // event and clear in one cycle: the event is kept
      wr(tirq_pkg::OFF_CTRL, {26'h0, tirq_pkg::OPM_TX, 4'h0});
      ev(5'h10, 4'h4, 5'h04);
      chk(irq_out, 1'b1);
      clr_by(3, 1, 0);
      // masked event stays pending and shows once enabled
      wr(tirq_pkg::OFF_ENABLE, 0);
      @(posedge ref_clk) state_status_bits <= ~state_status_bits;
      @(posedge ref_clk) #1 chk(irq_out, 1'b0);
      rdc(tirq_pkg::OFF_STATUS, 1);
      // read data stands one cycle only, then falls back to zero
      @(posedge ref_clk) #1 chk(bus_rdata, 32'h0);
      wr(tirq_pkg::OFF_ENABLE, 7);
      chk(irq_out, 1'b1);
      clr_by(4, 0, 0);
      // power flag raised under reset must interrupt once reset ends
      @(posedge ref_clk) begin
         reset         <= 1'b1;
         power_on_flag <= 1'b1;
      end
      repeat (2) @(posedge ref_clk);
      reset <= 1'b0;
      chk(irq_out, 1'b0);
      rdc(tirq_pkg::OFF_ENABLE, 7);
      chk(irq_out, 1'b1);
      rdc(tirq_pkg::OFF_STATUS, 1);
      conclude();
   end
endmodule : tb
bind tirq_irq_logic tirq_irq_sva #(.ST_W(ST_W)) tirq_irq_sva_inst (.ref_clk, .reset,
   .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .state_status_bits, .power_on_flag,
   .p_on_aux_flag, .tx_count, .rx_count, .src, .clr, .ctrl_out, .irq_out);

// [bench/tirq_host_model.sv]
// Purpose : host that services the request pin on its own
// Assumes : enabled by the bench only around tx traffic
// Notes   : reads status first, touches the buffer only if still high
`timescale 1ns/1ps
module tirq_host_model (
   input  wire logic ref_clk, // clock
   input  wire logic reset,   // sync reset
   input  wire logic auto_en, // service enable
   input  wire logic irq_out, // request pin
   output logic      rd_stb,  // status read pulse
   output logic      wr_stb   // tx buffer write pulse
);
   // idle, wait for read to land, then one look at the pin
   logic [1:0] st_q;
   always_ff @(posedge ref_clk) begin
      rd_stb <= 1'b0;
      wr_stb <= 1'b0;
      if (reset || !auto_en) begin
         st_q <= 2'h0;
      end else begin
         st_q <= st_q + 2'h1;
         if (st_q == 2'h0) begin
            st_q   <= {1'b0, irq_out};
            rd_stb <= irq_out;
         end
         if (st_q == 2'h2)
            wr_stb <= irq_out;
      end
   end
endmodule : tirq_host_model

// [bench/tirq_irq_sva.sv]
// Purpose : concurrent checks on the interrupt pin
// Assumes : enable tracked from bus writes, one clock
// Notes   : status, delete and hold antecedents skip the first edge after reset
`timescale 1ns/1ps
module tirq_irq_sva #(
   parameter int ST_W = 4                         // state bit count
) (
   input wire logic                       ref_clk,           // clock
   input wire logic                       reset,             // sync reset
   input wire logic [7:0]                 bus_addr,          // address
   input wire logic [31:0]                bus_wdata,         // write data
   input wire logic                       bus_wr,            // write strobe
   input wire logic                       bus_rd,            // read strobe
   input wire logic [31:0]                bus_rdata,         // read data
   input wire logic [ST_W-1:0]            state_status_bits, // state levels
   input wire logic                       power_on_flag,     // power-on level
   input wire logic                       p_on_aux_flag,     // aux level
   input wire logic [tirq_pkg::CNT_W-1:0] tx_count,          // tx bytes
   input wire logic [tirq_pkg::CNT_W-1:0] rx_count,          // rx bytes
   input wire tirq_pkg::tirq_src_t        src,               // source strobes
   input wire tirq_pkg::tirq_clr_t        clr,               // clear strobes
   input wire tirq_pkg::tirq_ctrl_t       ctrl_out,          // control copy
   input wire logic                       irq_out            // request pin
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////////////////////////
   // shadow enable; up_q hides the edge where reset-time values are compared
   logic [2:0] en_q;
   logic       up_q;
   always_ff @(posedge ref_clk) begin
      up_q <= !reset;
      if (reset)
         en_q <= 3'h7;
      else if (bus_wr && bus_addr == tirq_pkg::OFF_ENABLE)
         en_q <= bus_wdata[2:0];
   end
   // qualified source conditions
   wire [1:0] sel    = {ctrl_out.irq_threshold_sel_hi, ctrl_out.irq_threshold_sel_lo};
   wire [4:0] lvl    = (sel == 2'h3) ? 5'h00 : ({3'h0, sel} + 5'h01) << 2;
   wire       rx_ok  = ctrl_out.opm == tirq_pkg::OPM_RX && !ctrl_out.t_mode && en_q[2];
   wire       tx_hit = ctrl_out.opm == tirq_pkg::OPM_TX && !ctrl_out.t_mode && en_q[1]
                       && src.tx_dec_stb && tx_count == lvl;
   wire       rx_hit = rx_ok && !src.buf_read_busy && (sel == 2'h3 ? src.rx_err_stb
                       : src.rx_byte_stb && rx_count == lvl);
   ////////////////////////////////////////////////////////////////////////////////
   // nothing that could set or clear the pin besides what the property names
   sequence s_calm;
      up_q && !src.tx_dec_stb && !src.rx_byte_stb && !src.rx_err_stb && !src.bitchk_ok_stb
      && !bus_wr && !bus_rd && $stable(state_status_bits) && $stable(power_on_flag)
      && $stable(p_on_aux_flag);
   endsequence
   a_state_edge_irq: assert property (up_q && !$stable(state_status_bits) && en_q[0]
      |=> irq_out) else $error("state change gave no request");
   a_power_rise_irq: assert property (up_q && $rose(power_on_flag) && en_q[0]
      |=> irq_out) else $error("power-on rise gave no request");
   a_aux_rise_irq: assert property (up_q && $rose(p_on_aux_flag) && en_q[0]
      |=> irq_out) else $error("aux rise gave no request");
   a_tx_level_irq: assert property (tx_hit |=> irq_out)
      else $error("tx level gave no request");
   a_rx_level_irq: assert property (rx_hit |=> irq_out)
      else $error("rx level or error gave no request");
   a_bit_check_irq: assert property (rx_ok && !ctrl_out.p_mode && src.bitchk_ok_stb
      |=> irq_out) else $error("bit check gave no request");
   a_delete_clears_all: assert property (clr.delete_cmd ##0 s_calm |=> !irq_out)
      else $error("delete left request high");
   a_irq_hold_high: assert property (irq_out && clr == 4'h0 ##0 s_calm |=> irq_out)
      else $error("request dropped without clear");
endmodule : tirq_irq_sva

// [hw/tirq_irq_logic.sv]
// Purpose : interrupt request generation and clearing of the transceiver
// Assumes : all inputs synchronous to ref_clk; strobes are one cycle long
// Notes   : three pending groups (status, tx, rx) feed one level output
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps

module tirq_irq_logic #(
   parameter int ST_W = 4                           // number of state status bits
) (
   input  wire logic                      ref_clk,            // system clock, 40 MHz
   input  wire logic                      reset,              // synchronous, active high
   input  wire logic [7:0]                bus_addr,           // register byte address
   input  wire logic [31:0]               bus_wdata,          // register write data
   input  wire logic                      bus_wr,             // write strobe
   input  wire logic                      bus_rd,             // read strobe
   output logic      [31:0]               bus_rdata,          // read data, next cycle
   input  wire logic [ST_W-1:0]           state_status_bits,  // state status levels
   input  wire logic                      power_on_flag,      // power-on status level
   input  wire logic                      p_on_aux_flag,      // aux power-on level
   input  wire logic [tirq_pkg::CNT_W-1:0] tx_count,          // tx bytes left
   input  wire logic [tirq_pkg::CNT_W-1:0] rx_count,          // rx bytes held
   input  wire tirq_pkg::tirq_src_t       src,                // source strobes
   input  wire tirq_pkg::tirq_clr_t       clr,                // clearing strobes
   output tirq_pkg::tirq_ctrl_t           ctrl_out,           // control register copy
   output logic                           irq_out             // interrupt request pin
);

   ////////////////////////////////////////////////////////////////////////////
   // helper functions

   // byte level named by a threshold select code
   function automatic logic [tirq_pkg::CNT_W-1:0] thr_level(
      input logic [1:0] sel
   );
      logic [tirq_pkg::CNT_W-1:0] lvl;
      lvl = tirq_pkg::LVL_EMPTY;
      if (sel == tirq_pkg::THR_SEL_4) begin
         lvl = tirq_pkg::LVL_4;
      end else if (sel == tirq_pkg::THR_SEL_8) begin
         lvl = tirq_pkg::LVL_8;
      end else if (sel == tirq_pkg::THR_SEL_12) begin
         lvl = tirq_pkg::LVL_12;
      end
      return lvl;
   endfunction : thr_level

   // counter has reached the selected level
   function automatic logic thr_hit(
      input logic [1:0]                 sel,
      input logic [tirq_pkg::CNT_W-1:0] cnt
   );
      return cnt == thr_level(sel);
   endfunction : thr_hit

   ////////////////////////////////////////////////////////////////////////////
   // registers

   tirq_pkg::tirq_ctrl_t          ctrl_q;
   tirq_pkg::tirq_ctrl_t          ctrl_d;
   logic [tirq_pkg::GRP_W-1:0]    pend_q;
   logic [tirq_pkg::GRP_W-1:0]    pend_d;
   logic [tirq_pkg::GRP_W-1:0]    en_q;
   logic [tirq_pkg::GRP_W-1:0]    en_d;
   logic [ST_W-1:0]               st_q;
   logic                          pwr_q;
   logic                          aux_q;
   logic [31:0]                   rdata_q;
   logic [31:0]                   rdata_d;

   ////////////////////////////////////////////////////////////////////////////
   // register port decode

   logic                          hit_ctrl;
   logic                          hit_status;
   logic                          hit_enable;
   logic                          hit_clear;
   logic                          hit_state;
   logic                          wr_ctrl;
   logic                          wr_enable;
   logic                          wr_clear;
   logic                          rd_state;

   // address compare shared by reads and writes
   assign hit_ctrl   = (bus_addr == tirq_pkg::OFF_CTRL);
   assign hit_status = (bus_addr == tirq_pkg::OFF_STATUS);
   assign hit_enable = (bus_addr == tirq_pkg::OFF_ENABLE);
   assign hit_clear  = (bus_addr == tirq_pkg::OFF_CLEAR);
   assign hit_state  = (bus_addr == tirq_pkg::OFF_STATE);

   // strobes qualified by address; writes elsewhere are dropped
   assign wr_ctrl    = bus_wr && hit_ctrl;
   assign wr_enable  = bus_wr && hit_enable;
   assign wr_clear   = bus_wr && hit_clear;
   assign rd_state   = bus_rd && hit_state;

   ////////////////////////////////////////////////////////////////////////////
   // operating mode

   logic                          tx_mode;
   logic                          rx_mode;
   logic                          buffered;
   logic [1:0]                    thr_sel;
   logic                          sel_end;

   // modes decoded from the control register
   assign tx_mode  = (ctrl_q.opm == tirq_pkg::OPM_TX);
   assign rx_mode  = (ctrl_q.opm == tirq_pkg::OPM_RX);
   assign buffered = !ctrl_q.t_mode;
   assign thr_sel  = {ctrl_q.irq_threshold_sel_hi, ctrl_q.irq_threshold_sel_lo};
   assign sel_end  = (thr_sel == tirq_pkg::THR_SEL_END);

   ////////////////////////////////////////////////////////////////////////////
   // status register events

   logic                          st_change;
   logic                          pwr_rise;
   logic                          aux_rise;
   logic                          sts_evt;

   // both directions of every state bit count as an event
   assign st_change = |(state_status_bits ^ st_q);
   // power flags only interrupt on appearance, never on loss
   assign pwr_rise  = power_on_flag && !pwr_q;
   assign aux_rise  = p_on_aux_flag && !aux_q;
   assign sts_evt   = st_change || pwr_rise || aux_rise;

   ////////////////////////////////////////////////////////////////////////////
   // transmit buffer events

   logic                          tx_evt;

   // fires only on the decrement that lands on the level, so a refill
   // passing upward through the same level does not interrupt
   assign tx_evt = tx_mode && buffered && src.tx_dec_stb
                   && thr_hit(thr_sel, tx_count);

   ////////////////////////////////////////////////////////////////////////////
   // receive buffer events

   logic                          rx_cnt_hit;
   logic                          rx_err_hit;
   logic                          rx_buf_evt;
   logic                          bitchk_evt;
   logic                          rx_evt;

   // the fourth select code turns the count source into the error source
   assign rx_cnt_hit = src.rx_byte_stb && !sel_end && thr_hit(thr_sel, rx_count);
   assign rx_err_hit = src.rx_err_stb && sel_end;

   // a host draining the buffer must not be re-interrupted by it
   assign rx_buf_evt = rx_mode && buffered && !src.buf_read_busy
                       && (rx_cnt_hit || rx_err_hit);

   // bit check has no meaning in pattern mode
   assign bitchk_evt = rx_mode && buffered && !ctrl_q.p_mode
                       && src.bitchk_ok_stb;
   assign rx_evt     = rx_buf_evt || bitchk_evt;

   ////////////////////////////////////////////////////////////////////////////
   // clearing operations

   logic                          cfg_clear;
   logic [tirq_pkg::GRP_W-1:0]    sw_clear;
   logic [tirq_pkg::GRP_W-1:0]    grp_clear;
   logic [tirq_pkg::GRP_W-1:0]    grp_evt;

   // a write of the local control register counts as a config write
   assign cfg_clear = clr.cfg_write || wr_ctrl;

   // write-one-to-clear bits from the register port
   assign sw_clear  = wr_clear ? bus_wdata[tirq_pkg::GRP_W-1:0] : '0;

   // each group has its own clearing set
   assign grp_clear[tirq_pkg::GRP_STS] = clr.status_read || rd_state
                                         || clr.delete_cmd
                                         || sw_clear[tirq_pkg::GRP_STS];
   assign grp_clear[tirq_pkg::GRP_TX]  = clr.tx_buf_write || cfg_clear
                                         || clr.delete_cmd
                                         || sw_clear[tirq_pkg::GRP_TX];
   assign grp_clear[tirq_pkg::GRP_RX]  = cfg_clear || clr.delete_cmd
                                         || sw_clear[tirq_pkg::GRP_RX];

   // events gathered in group order
   assign grp_evt[tirq_pkg::GRP_STS] = sts_evt;
   assign grp_evt[tirq_pkg::GRP_TX]  = tx_evt;
   assign grp_evt[tirq_pkg::GRP_RX]  = rx_evt;

   ////////////////////////////////////////////////////////////////////////////
   // next values

   // a set in the clearing cycle wins so no event is lost
   assign pend_d = grp_evt | (pend_q & ~grp_clear);

   // control and enable take the low bits of the write data
   assign ctrl_d = wr_ctrl ? tirq_pkg::tirq_ctrl_t'(bus_wdata[tirq_pkg::CTRL_W-1:0])
                           : ctrl_q;
   assign en_d   = wr_enable ? bus_wdata[tirq_pkg::GRP_W-1:0] : en_q;

   ////////////////////////////////////////////////////////////////////////////
   // read data

   logic [31:0]                   rd_mux;

   // unmapped addresses and the clear register read as zero
   assign rd_mux = hit_ctrl   ? 32'(ctrl_q)
                 : hit_status ? 32'(pend_q)
                 : hit_enable ? 32'(en_q)
                 : hit_state  ? 32'({p_on_aux_flag, power_on_flag, state_status_bits})
                 : 32'h00000000;

   // data stands only in the cycle after the read strobe
   assign rdata_d = bus_rd ? rd_mux : 32'h00000000;

   ////////////////////////////////////////////////////////////////////////////
   // flip-flops

   // configuration and interrupt state
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ctrl_q <= tirq_pkg::CTRL_RST;
         en_q   <= tirq_pkg::ENABLE_RST;
         pend_q <= '0;
      end else begin
         ctrl_q <= ctrl_d;
         en_q   <= en_d;
         pend_q <= pend_d;
      end
   end

   // previous input levels; cleared at reset so a flag already high
   // when reset ends raises the power-on interrupt
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         st_q  <= '0;
         pwr_q <= 1'b0;
         aux_q <= 1'b0;
      end else begin
         st_q  <= state_status_bits;
         pwr_q <= power_on_flag;
         aux_q <= p_on_aux_flag;
      end
   end

   // read data register
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         rdata_q <= 32'h00000000;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   // level request, high while any enabled group is pending
   assign irq_out   = |(pend_q & en_q);
   assign bus_rdata = rdata_q;
   assign ctrl_out  = ctrl_q;

endmodule : tirq_irq_logic

// [hw/tirq_pkg.sv]
// Purpose : constants and carrier types of the transceiver interrupt logic
// Assumes : one clock, synchronous active-high reset, word-aligned registers
// Notes   : all offsets are byte addresses on the plain register port
// Behaviour
// - irq high on enabled event, held until cleared
// - any state bit change raises irq
// - power-on flag rising raises irq
// - auxiliary power-on flag rising raises irq
// - status events cleared by status read or delete
// - tx buffer level 4/8/12/empty raises irq
// - tx irq cleared by buffer/config write or delete
// - rx buffer 4/8/12 or rx error raises irq
// - successful bit check raises irq, pattern mode off
// - rx irq cleared by config write or delete
// - no rx count/error irq during buffer read
// - threshold from two select bits, counting down
// - transparent mode disables buffer count sources
package tirq_pkg;

   // register byte offsets
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_ENABLE = 8'h08;
   localparam logic [7:0] OFF_CLEAR  = 8'h0c;
   localparam logic [7:0] OFF_STATE  = 8'h10;

   // interrupt group bit positions in status, enable and clear
   localparam int GRP_STS = 0;
   localparam int GRP_TX  = 1;
   localparam int GRP_RX  = 2;
   localparam int GRP_W   = 3;

   // control register width and reset values
   localparam int              CTRL_W     = 6;
   localparam logic [5:0]      CTRL_RST   = 6'h00;
   localparam logic [GRP_W-1:0] ENABLE_RST = 3'h7;

   // operating modes held in the control register
   localparam logic [1:0] OPM_TX = 2'h1;
   localparam logic [1:0] OPM_RX = 2'h2;

   // threshold select codes and the byte levels they name
   localparam logic [1:0] THR_SEL_4   = 2'h0;
   localparam logic [1:0] THR_SEL_8   = 2'h1;
   localparam logic [1:0] THR_SEL_12  = 2'h2;
   localparam logic [1:0] THR_SEL_END = 2'h3;
   localparam int         CNT_W       = 5;
   localparam logic [4:0] LVL_4       = 5'h04;
   localparam logic [4:0] LVL_8       = 5'h08;
   localparam logic [4:0] LVL_12      = 5'h0c;
   localparam logic [4:0] LVL_EMPTY   = 5'h00;

   // control register fields, msb first: bit 0 is the low threshold select
   typedef struct packed {
      logic [1:0] opm;
      logic       p_mode;
      logic       t_mode;
      logic       irq_threshold_sel_hi;
      logic       irq_threshold_sel_lo;
   } tirq_ctrl_t;

   // one-cycle event strobes and levels from the buffer and receiver
   typedef struct packed {
      logic tx_dec_stb;
      logic rx_byte_stb;
      logic rx_err_stb;
      logic bitchk_ok_stb;
      logic buf_read_busy;
   } tirq_src_t;

   // one-cycle clearing strobes from the serial interface
   typedef struct packed {
      logic status_read;
      logic tx_buf_write;
      logic cfg_write;
      logic delete_cmd;
   } tirq_clr_t;

endpackage : tirq_pkg
